// >>> rtl/swt_pkg.sv
package swt_pkg;

	// ----------------------------------------------------------------
	// register offsets on the serial register port
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_PIN0_CFG      = 7'h0b;
	localparam logic [6:0] ADDR_PIN1_CFG      = 7'h0c;
	localparam logic [6:0] ADDR_PIN2_CFG      = 7'h0d;
	localparam logic [6:0] ADDR_IO_PORT_CFG   = 7'h0e;
	localparam logic [6:0] ADDR_WAKE_EXP      = 7'h14;
	localparam logic [6:0] ADDR_WAKE_MANT_HI  = 7'h15;
	localparam logic [6:0] ADDR_WAKE_MANT_LO  = 7'h16;
	localparam logic [6:0] ADDR_WAKE_CNT_HI   = 7'h17;
	localparam logic [6:0] ADDR_WAKE_CNT_LO   = 7'h18;

	// ----------------------------------------------------------------
	// reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE           = 8'h00;
	localparam logic [7:0] BYTE_ZERO          = 8'h00;
	localparam int         CFG_DRV_MSB        = 7;
	localparam int         CFG_DRV_LSB        = 6;
	localparam int         CFG_PUP_BIT        = 5;
	localparam int         CFG_FN_MSB         = 4;
	localparam int         EXP_R_MSB          = 5;
	localparam int         EXP_R_LSB          = 2;
	localparam int         EXP_D_MSB          = 1;
	localparam logic [7:0] EXP_USED_MASK      = 8'h3f;
	localparam logic [7:0] IO_PORT_MASK       = 8'h7f;
	localparam int         NUM_PINS           = 3;

	// ----------------------------------------------------------------
	// pin function codes (code zero is pin specific)
	// ----------------------------------------------------------------
	localparam logic [4:0] FN_DEFAULT         = 5'h00;
	localparam logic [4:0] FN_WAKE_TIMER      = 5'h01;
	localparam logic [4:0] FN_DIRECT_OUT      = 5'h0a;
	localparam logic [4:0] FN_DIRECT_IN       = 5'h03;

	// ----------------------------------------------------------------
	// timing: low-frequency clock and wake period arithmetic
	// ----------------------------------------------------------------
	localparam int         LF_CLK_HZ          = 32768;
	localparam int         REF_CLK_HZ         = 100000000;
	localparam int         REF_PER_LF_CYCLES  = REF_CLK_HZ / LF_CLK_HZ;
	localparam logic [18:0] WAKE_BASE_TICKS   = 19'h0_0004;
	localparam logic [18:0] PRESC_ONE         = 19'h0_0001;
	localparam logic [15:0] MANT_ONE          = 16'h0001;
	localparam logic [15:0] MANT_ZERO         = 16'h0000;
	localparam logic [3:0]  BIT_CNT_BYTE      = 4'h8;
	localparam logic [3:0]  BIT_CNT_ZERO      = 4'h0;
	localparam logic [3:0]  BIT_CNT_ONE       = 4'h1;
	localparam logic [6:0]  ADDR_ONE          = 7'h01;

	// serial port sequencer states
	typedef enum logic [2:0] {
		SWT_SPI_IDLE = 3'b001,
		SWT_SPI_ADDR = 3'b010,
		SWT_SPI_DATA = 3'b100
	} swt_spi_state_t;

endpackage

// >>> rtl/swt_spi_slave.sv
`timescale 1ns/10ps
`default_nettype none

module swt_spi_slave (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       spi_sel_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_sdi,
	output logic            spi_sdo,
	output logic [6:0]      reg_addr,
	output logic            reg_wr_en,
	output logic [7:0]      reg_wr_data,
	input  wire logic [7:0] reg_rd_data
);

	// ----------------------------------------------------------------
	// serial clock edges, sampled on ref_clk
	// ----------------------------------------------------------------
	logic                  sclk_prev_r;
	logic                  sclk_rise;
	logic                  sclk_fall;
	swt_pkg::swt_spi_state_t state_r;
	logic [3:0]            bit_cnt_r;
	logic [7:0]            shift_in_r;
	logic [7:0]            shift_out_r;
	logic                  is_write_r;
	logic                  byte_end_r;
	logic [7:0]            shift_in_nxt;

	assign sclk_rise    = spi_sclk & ~sclk_prev_r;
	assign sclk_fall    = ~spi_sclk & sclk_prev_r;
	assign shift_in_nxt = {shift_in_r[6:0], spi_sdi};

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			sclk_prev_r <= 1'b0;
		else
			sclk_prev_r <= spi_sclk;
	end

	// ----------------------------------------------------------------
	// receive side: first bit is write flag, seven address bits, then
	// data bytes; the address steps after every byte for bursts
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r     <= swt_pkg::SWT_SPI_IDLE;
			bit_cnt_r   <= swt_pkg::BIT_CNT_ZERO;
			shift_in_r  <= swt_pkg::BYTE_ZERO;
			is_write_r  <= 1'b0;
			byte_end_r  <= 1'b0;
			reg_addr    <= 7'h00;
			reg_wr_en   <= 1'b0;
			reg_wr_data <= swt_pkg::BYTE_ZERO;
		end
		else
		begin
			reg_wr_en  <= 1'b0;
			byte_end_r <= 1'b0;
			// step one cycle after the byte, so the write strobe sees its own address
			if (byte_end_r)
				reg_addr <= reg_addr + swt_pkg::ADDR_ONE;
			if (spi_sel_n)
			begin
				state_r   <= swt_pkg::SWT_SPI_IDLE;
				bit_cnt_r <= swt_pkg::BIT_CNT_ZERO;
			end
			else
			begin
				case (state_r)
					swt_pkg::SWT_SPI_IDLE:
					begin
						state_r   <= swt_pkg::SWT_SPI_ADDR;
						bit_cnt_r <= swt_pkg::BIT_CNT_ZERO;
					end
					swt_pkg::SWT_SPI_ADDR:
					begin
						if (sclk_rise)
						begin
							shift_in_r <= shift_in_nxt;
							bit_cnt_r  <= bit_cnt_r + swt_pkg::BIT_CNT_ONE;
							if (bit_cnt_r == swt_pkg::BIT_CNT_BYTE - swt_pkg::BIT_CNT_ONE)
							begin
								is_write_r <= shift_in_nxt[7];
								reg_addr   <= shift_in_nxt[6:0];
								bit_cnt_r  <= swt_pkg::BIT_CNT_ZERO;
								state_r    <= swt_pkg::SWT_SPI_DATA;
							end
						end
					end
					swt_pkg::SWT_SPI_DATA:
					begin
						if (sclk_rise)
						begin
							shift_in_r <= shift_in_nxt;
							bit_cnt_r  <= bit_cnt_r + swt_pkg::BIT_CNT_ONE;
							if (bit_cnt_r == swt_pkg::BIT_CNT_BYTE - swt_pkg::BIT_CNT_ONE)
							begin
								reg_wr_en   <= is_write_r;
								reg_wr_data <= shift_in_nxt;
								bit_cnt_r   <= swt_pkg::BIT_CNT_ZERO;
								byte_end_r  <= 1'b1;
							end
						end
					end
					default:
						state_r <= swt_pkg::SWT_SPI_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit side: a byte is loaded on the first falling edge of each
	// data byte, so the read mux has had a full half period to settle
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			shift_out_r <= swt_pkg::BYTE_ZERO;
			spi_sdo     <= 1'b0;
		end
		else if (spi_sel_n)
			spi_sdo <= 1'b0;
		else if (sclk_fall && state_r == swt_pkg::SWT_SPI_DATA && !is_write_r)
		begin
			if (bit_cnt_r == swt_pkg::BIT_CNT_ZERO)
			begin
				spi_sdo     <= reg_rd_data[7];
				shift_out_r <= {reg_rd_data[6:0], 1'b0};
			end
			else
			begin
				spi_sdo     <= shift_out_r[7];
				shift_out_r <= {shift_out_r[6:0], 1'b0};
			end
		end
	end

endmodule // swt_spi_slave

`default_nettype wire

// >>> rtl/swt_sleep_wake_timer.sv
// Summary of operation
// - wake timer ticks from the 32.768 kHz RC source unless crystal is selected.
// - run enable high on sleep entry starts counting the programmed period.
// - expiry asserts the interrupt pin when the timer interrupt enable is set.
// - live 16-bit count readable anytime, high byte at 17, low at 18.
// - period is 4 times mantissa times two to the exponent, over two to the fine divider, low-clock ticks.
// - exponent bits 5:2 and fine divider 1:0 at 14; mantissa at 15, 16.
// - enabled expiry drives interrupt pin low and requests the 30 MHz crystal.
// - with interrupt off and timer pin function, no state change on expiry.
// - outside shutdown, crystal select hands pin 0 over to the external 32 kHz crystal.
// - crystal select clocks the timer and other slow functions from the crystal.
// - in shutdown every general purpose pin is pulled low.
// - three pins, each config holds drive 7:6, pull-up 5, function 4:0.
// - function zero is power-on reset, its inverse, and the controller clock.
// - a larger drive strength code selects a stronger output driver.
`timescale 1ns/10ps
`default_nettype none

module swt_sleep_wake_timer (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       spi_sel_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_sdi,
	output logic            spi_sdo,
	input  wire logic       lf_rc_osc,
	input  wire logic       lf_xtal_osc,
	input  wire logic       low_freq_crystal_select,
	input  wire logic       wake_run_enable,
	input  wire logic       wake_irq_enable,
	input  wire logic       wake_irq_ack,
	input  wire logic       sleep_mode,
	input  wire logic       shutdown_mode,
	input  wire logic       por_active,
	input  wire logic       mcu_clk,
	input  wire logic [2:0] pin_in,
	output logic [2:0]      pin_out,
	output logic [2:0]      pin_oe_n,
	output logic [5:0]      pin_drive_strength,
	output logic [2:0]      pin_pullup_enable,
	output logic            interrupt_request_pin_n,
	output logic            xtal_wake_request,
	output logic            lf_clk_is_crystal
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0]  pin_cfg_r [swt_pkg::NUM_PINS];
	logic [7:0]  io_port_cfg_r;
	logic [7:0]  wake_exp_r;
	logic [15:0] wake_mant_r;
	logic [15:0] wake_timer_r;
	logic [18:0] presc_r;
	logic [6:0]  reg_addr;
	logic        reg_wr_en;
	logic [7:0]  reg_wr_data;
	logic [7:0]  reg_rd_data;
	logic        lf_prev_r;
	logic        lf_level;
	logic        lf_tick;
	logic        sleep_prev_r;
	logic        armed_r;
	logic        expire;
	logic        wake_flag_r;
	logic [18:0] presc_target;

	// period of one mantissa step in low-clock ticks
	function automatic logic [18:0] wake_step_ticks(input logic [7:0] exp_reg);
		logic [3:0] r_val;
		logic [1:0] d_val;
		r_val = exp_reg[swt_pkg::EXP_R_MSB:swt_pkg::EXP_R_LSB];
		d_val = exp_reg[swt_pkg::EXP_D_MSB:0];
		wake_step_ticks = (swt_pkg::WAKE_BASE_TICKS << r_val) >> d_val;
	endfunction

	// decode of a pin's function field
	function automatic logic [4:0] pin_fn(input logic [7:0] cfg);
		pin_fn = cfg[swt_pkg::CFG_FN_MSB:0];
	endfunction

	// ----------------------------------------------------------------
	// serial register port
	// ----------------------------------------------------------------
	swt_spi_slave u_spi (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.spi_sel_n   (spi_sel_n),
		.spi_sclk    (spi_sclk),
		.spi_sdi     (spi_sdi),
		.spi_sdo     (spi_sdo),
		.reg_addr    (reg_addr),
		.reg_wr_en   (reg_wr_en),
		.reg_wr_data (reg_wr_data),
		.reg_rd_data (reg_rd_data)
	);

	// writes to the configuration registers; all reset to zero
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < swt_pkg::NUM_PINS; i++)
				pin_cfg_r[i] <= swt_pkg::RST_BYTE;
			io_port_cfg_r <= swt_pkg::RST_BYTE;
			wake_exp_r    <= swt_pkg::RST_BYTE;
			wake_mant_r   <= {swt_pkg::RST_BYTE, swt_pkg::RST_BYTE};
		end
		else if (reg_wr_en)
		begin
			case (reg_addr)
				swt_pkg::ADDR_PIN0_CFG:     pin_cfg_r[0] <= reg_wr_data;
				swt_pkg::ADDR_PIN1_CFG:     pin_cfg_r[1] <= reg_wr_data;
				swt_pkg::ADDR_PIN2_CFG:     pin_cfg_r[2] <= reg_wr_data;
				swt_pkg::ADDR_IO_PORT_CFG:  io_port_cfg_r <= reg_wr_data & swt_pkg::IO_PORT_MASK;
				swt_pkg::ADDR_WAKE_EXP:     wake_exp_r <= reg_wr_data & swt_pkg::EXP_USED_MASK;
				swt_pkg::ADDR_WAKE_MANT_HI: wake_mant_r[15:8] <= reg_wr_data;
				swt_pkg::ADDR_WAKE_MANT_LO: wake_mant_r[7:0] <= reg_wr_data;
				default:                    ;
			endcase
		end
	end

	// read mux; the dio bits show the pin level when a pin is an input
	always_comb
	begin
		reg_rd_data = swt_pkg::BYTE_ZERO;
		case (reg_addr)
			swt_pkg::ADDR_PIN0_CFG:     reg_rd_data = pin_cfg_r[0];
			swt_pkg::ADDR_PIN1_CFG:     reg_rd_data = pin_cfg_r[1];
			swt_pkg::ADDR_PIN2_CFG:     reg_rd_data = pin_cfg_r[2];
			swt_pkg::ADDR_IO_PORT_CFG:
			begin
				reg_rd_data = io_port_cfg_r;
				for (int i = 0; i < swt_pkg::NUM_PINS; i++)
					if (pin_fn(pin_cfg_r[i]) == swt_pkg::FN_DIRECT_IN)
						reg_rd_data[i] = pin_in[i];
			end
			swt_pkg::ADDR_WAKE_EXP:     reg_rd_data = wake_exp_r;
			swt_pkg::ADDR_WAKE_MANT_HI: reg_rd_data = wake_mant_r[15:8];
			swt_pkg::ADDR_WAKE_MANT_LO: reg_rd_data = wake_mant_r[7:0];
			swt_pkg::ADDR_WAKE_CNT_HI:  reg_rd_data = wake_timer_r[15:8];
			swt_pkg::ADDR_WAKE_CNT_LO:  reg_rd_data = wake_timer_r[7:0];
			default:                    reg_rd_data = swt_pkg::BYTE_ZERO;
		endcase
	end

	// ----------------------------------------------------------------
	// low-frequency clock selection and tick
	// ----------------------------------------------------------------
	// the slow clocks are sampled as plain levels; one tick per rising edge.
	// a source change may give one extra tick, harmless for a wake period
	assign lf_level = low_freq_crystal_select ? lf_xtal_osc : lf_rc_osc;
	assign lf_tick  = lf_level & ~lf_prev_r;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			lf_prev_r         <= 1'b0;
			lf_clk_is_crystal <= 1'b0;
		end
		else
		begin
			lf_prev_r         <= lf_level;
			lf_clk_is_crystal <= low_freq_crystal_select;
		end
	end

	// ----------------------------------------------------------------
	// wake timer
	// ----------------------------------------------------------------
	// run enable is caught at the entry into sleep; dropping it later in sleep stops the count
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sleep_prev_r <= 1'b0;
			armed_r      <= 1'b0;
		end
		else
		begin
			sleep_prev_r <= sleep_mode;
			if (!sleep_mode || !wake_run_enable)
				armed_r <= 1'b0;
			else if (!sleep_prev_r)
				armed_r <= wake_run_enable;
		end
	end

	assign presc_target = wake_step_ticks(wake_exp_r);
	// a zero mantissa never expires rather than firing every tick
	assign expire = armed_r && lf_tick && (presc_r + swt_pkg::PRESC_ONE >= presc_target)
		&& (wake_mant_r != swt_pkg::MANT_ZERO)
		&& (wake_timer_r + swt_pkg::MANT_ONE >= wake_mant_r);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			presc_r      <= 19'h0_0000;
			wake_timer_r <= swt_pkg::MANT_ZERO;
		end
		else if (!armed_r)
		begin
			presc_r      <= 19'h0_0000;
			wake_timer_r <= swt_pkg::MANT_ZERO;
		end
		else if (lf_tick)
		begin
			if (presc_r + swt_pkg::PRESC_ONE >= presc_target)
			begin
				presc_r <= 19'h0_0000;
				if (expire)
					wake_timer_r <= swt_pkg::MANT_ZERO;
				else
					wake_timer_r <= wake_timer_r + swt_pkg::MANT_ONE;
			end
			else
				presc_r <= presc_r + swt_pkg::PRESC_ONE;
		end
	end

	// ----------------------------------------------------------------
	// expiry effects: interrupt, crystal wake, pin event flag
	// ----------------------------------------------------------------
	// set beats a simultaneous acknowledge so an expiry is never lost
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			interrupt_request_pin_n <= 1'b1;
			xtal_wake_request       <= 1'b0;
		end
		else
		begin
			if (expire && wake_irq_enable)
				interrupt_request_pin_n <= 1'b0;
			else if (wake_irq_ack)
				interrupt_request_pin_n <= 1'b1;
			if (expire && wake_irq_enable)
				xtal_wake_request <= 1'b1;
			else if (!sleep_mode)
				xtal_wake_request <= 1'b0;
		end
	end

	// set on each expiry and cleared by the next low-clock tick, for the timer pin function; no state change
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			wake_flag_r <= 1'b0;
		else if (!armed_r)
			wake_flag_r <= 1'b0;
		else if (expire)
			wake_flag_r <= 1'b1;
		else if (lf_tick)
			wake_flag_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// general purpose pins
	// ----------------------------------------------------------------
	// every pin output is registered, so the controller clock on pin 2
	// lags by one ref_clk; acceptable for a slow controller clock
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_out            <= 3'h0;
			pin_oe_n           <= 3'h7;
			pin_drive_strength <= 6'h00;
			pin_pullup_enable  <= 3'h0;
		end
		else
		begin
			for (int i = 0; i < swt_pkg::NUM_PINS; i++)
			begin
				pin_drive_strength[2*i +: 2] <=
					pin_cfg_r[i][swt_pkg::CFG_DRV_MSB:swt_pkg::CFG_DRV_LSB];
				pin_pullup_enable[i] <= pin_cfg_r[i][swt_pkg::CFG_PUP_BIT];
				pin_oe_n[i]          <= 1'b0;
				case (pin_fn(pin_cfg_r[i]))
					swt_pkg::FN_DEFAULT:
					begin
						if (i == 0)
							pin_out[i] <= por_active;
						else if (i == 1)
							pin_out[i] <= ~por_active;
						else
							pin_out[i] <= mcu_clk;
					end
					swt_pkg::FN_WAKE_TIMER: pin_out[i] <= wake_flag_r;
					swt_pkg::FN_DIRECT_OUT: pin_out[i] <= io_port_cfg_r[i];
					swt_pkg::FN_DIRECT_IN:
					begin
						pin_out[i]  <= 1'b0;
						pin_oe_n[i] <= 1'b1;
					end
					default:                pin_out[i] <= 1'b0;
				endcase
				if (i == 0 && low_freq_crystal_select)
				begin
					pin_out[i]           <= 1'b0;
					pin_oe_n[i]          <= 1'b1;
					pin_pullup_enable[i] <= 1'b0;
				end
				if (shutdown_mode)
				begin
					pin_out[i]           <= 1'b0;
					pin_oe_n[i]          <= 1'b0;
					pin_pullup_enable[i] <= 1'b0;
				end
			end
		end
	end

endmodule // swt_sleep_wake_timer

`default_nettype wire

// >>> verification/swt_sleep_wake_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none

module swt_sleep_wake_timer_chk (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       spi_sel_n,
	input  wire logic       spi_sdo,
	input  wire logic       low_freq_crystal_select,
	input  wire logic       wake_irq_enable,
	input  wire logic       wake_irq_ack,
	input  wire logic       sleep_mode,
	input  wire logic       shutdown_mode,
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe_n,
	input  wire logic [2:0] pin_pullup_enable,
	input  wire logic       interrupt_request_pin_n,
	input  wire logic       xtal_wake_request,
	input  wire logic       lf_clk_is_crystal
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// pin, source and interrupt relations
	// ----------------------------------------------------------------
	// two-cycle levels: outputs are registered, so they answer one edge late
	sequence deselected_s;
		spi_sel_n ##1 spi_sel_n;
	endsequence
	sequence awake_s;
		!sleep_mode ##1 !sleep_mode;
	endsequence

	shut_pins_a: assert property (
		shutdown_mode |=> pin_out == 3'h0 && pin_oe_n == 3'h0 && pin_pullup_enable == 3'h0)
		else $error("pins not pulled low in shutdown");
	xtal_src_a: assert property (low_freq_crystal_select |=> lf_clk_is_crystal)
		else $error("timer not moved to crystal source");
	xtal_pin0_a: assert property (
		low_freq_crystal_select && !shutdown_mode |=> pin_oe_n[0])
		else $error("pin 0 still driven with crystal selected");
	irq_cause_a: assert property ($fell(interrupt_request_pin_n) |-> $past(wake_irq_enable))
		else $error("interrupt raised while disabled");
	irq_hold_a: assert property (
		!interrupt_request_pin_n && !wake_irq_ack |=> !interrupt_request_pin_n)
		else $error("interrupt released without ack");
	irq_clear_a: assert property ($rose(interrupt_request_pin_n) |-> $past(wake_irq_ack))
		else $error("interrupt cleared without ack");
	wake_cause_a: assert property (
		$rose(xtal_wake_request) |-> $past(wake_irq_enable) && !interrupt_request_pin_n)
		else $error("crystal woken without enabled interrupt");
	wake_drop_a: assert property (awake_s |=> !xtal_wake_request)
		else $error("crystal request held outside sleep");
	sdo_idle_a: assert property (deselected_s |-> !spi_sdo)
		else $error("serial out active while deselected");
endmodule // swt_sleep_wake_timer_chk

bind swt_sleep_wake_timer swt_sleep_wake_timer_chk u_chk (
	.ref_clk(ref_clk), .rst(rst), .spi_sel_n(spi_sel_n), .spi_sdo(spi_sdo),
	.low_freq_crystal_select(low_freq_crystal_select), .wake_irq_enable(wake_irq_enable),
	.wake_irq_ack(wake_irq_ack), .sleep_mode(sleep_mode), .shutdown_mode(shutdown_mode),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_enable(pin_pullup_enable),
	.interrupt_request_pin_n(interrupt_request_pin_n),
	.xtal_wake_request(xtal_wake_request), .lf_clk_is_crystal(lf_clk_is_crystal)
);

`default_nettype wire

// >>> verification/swt_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module swt_host_model (
	input  wire logic ref_clk,
	output logic      spi_sel_n,
	output logic      spi_sclk,
	output logic      spi_sdi,
	input  wire logic spi_sdo
);
	initial
	begin
		spi_sel_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
	end

	// half a serial period: three ref cycles keeps each level seen on three ref_clk edges
	task automatic half();
		repeat (3) @(negedge ref_clk);
	endtask

	// one command of flag, address and one byte; read bits taken just before each rise
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] sh;
		sh = {wr, a, d};
		q = 8'h00;
		@(negedge ref_clk);
		spi_sel_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			spi_sdi = sh[i];
			half();
			if (i < 8)
				q[i] = spi_sdo;
			spi_sclk = 1'b1;
			half();
			spi_sclk = 1'b0;
		end
		half();
		spi_sel_n = 1'b1;
		spi_sdi = ~spi_sdi; // released line shows no stale value
		half();
	endtask
endmodule // swt_host_model

`default_nettype wire

// >>> verification/tb_swt_sleep_wake_timer.sv
`timescale 1ns/10ps
`default_nettype none

module tb_swt_sleep_wake_timer;
	logic       ref_clk, rst, spi_sel_n, spi_sclk, spi_sdi, spi_sdo, lf_rc_osc, lf_xtal_osc;
	logic       low_freq_crystal_select, wake_run_enable, wake_irq_enable, wake_irq_ack;
	logic       sleep_mode, shutdown_mode, por_active, mcu_clk, interrupt_request_pin_n;
	logic       xtal_wake_request, lf_clk_is_crystal;
	logic [2:0] pin_in, pin_out, pin_oe_n, pin_pullup_enable;
	logic [5:0] pin_drive_strength;
	logic [7:0] d;
	logic [6:0] addrs [10] = '{7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h30};
	int         bad_count, n_tests, seed, rises, stop_at, ph;
	int         mdl [128];
	bit         lf_run;

	swt_sleep_wake_timer u_swt_sleep_wake_timer (.ref_clk(ref_clk), .rst(rst),
		.spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.lf_rc_osc(lf_rc_osc), .lf_xtal_osc(lf_xtal_osc), .wake_irq_ack(wake_irq_ack),
		.low_freq_crystal_select(low_freq_crystal_select), .wake_run_enable(wake_run_enable),
		.wake_irq_enable(wake_irq_enable), .sleep_mode(sleep_mode), .mcu_clk(mcu_clk),
		.shutdown_mode(shutdown_mode), .por_active(por_active), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_drive_strength(pin_drive_strength),
		.pin_pullup_enable(pin_pullup_enable), .lf_clk_is_crystal(lf_clk_is_crystal),
		.interrupt_request_pin_n(interrupt_request_pin_n), .xtal_wake_request(xtal_wake_request));
	swt_host_model u_swt_host_model (.ref_clk(ref_clk), .spi_sel_n(spi_sel_n),
		.spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

	// ----------------------------------------------------------------
	// clocks and shared tasks
	// ----------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// slow clocks compressed to keep the run short; both pause once the target is hit,
	// which freezes the live count for reading
	always @(negedge ref_clk)
	begin
		if (lf_run && rises < stop_at)
		begin
			ph = ph + 1;
			if (ph % 8 == 0)
				lf_rc_osc = ~lf_rc_osc;
			if (ph % 5 == 0)
				lf_xtal_osc = ~lf_xtal_osc;
			if (low_freq_crystal_select ? (ph % 5 == 0 && lf_xtal_osc) : (ph % 8 == 0 && lf_rc_osc))
				rises = rises + 1;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// writable bits per address; read-only and unmapped places keep nothing
	function automatic logic [7:0] wmask(input logic [6:0] a);
		case (a)
			7'h0b, 7'h0c, 7'h0d, 7'h15, 7'h16: return 8'hff;
			7'h14: return 8'h3f;
			7'h0e: return 8'h7f;
			default: return 8'h00;
		endcase
	endfunction

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] q;
		u_swt_host_model.xfer(1'b1, a, v, q);
		mdl[a] = v & wmask(a);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_swt_host_model.xfer(1'b0, a, 8'h00, q);
		chk(16'(q), 16'(e));
	endtask

	task automatic go_to(input int n);
		stop_at = n;
		lf_run = 1'b1;
		while (rises < n)
			@(negedge ref_clk);
		repeat (20) @(negedge ref_clk);
	endtask

	// one sleep period run: live count one step short, then two expiries
	task automatic wake(input logic [3:0] r, input logic [1:0] dv, input logic [15:0] m,
		input logic xt, input logic ie);
		int step;
		step = (4 << r) >> dv;
		low_freq_crystal_select = xt;
		wake_irq_enable = ie;
		wr(swt_pkg::ADDR_WAKE_EXP, {2'h0, r, dv});
		wr(swt_pkg::ADDR_WAKE_MANT_HI, m[15:8]);
		wr(swt_pkg::ADDR_WAKE_MANT_LO, m[7:0]);
		wake_run_enable = 1'b1;
		sleep_mode = 1'b1;
		rises = 0;
		@(negedge ref_clk);
		go_to(step * (m - 1));
		rd(swt_pkg::ADDR_WAKE_CNT_HI, 8'((m - 1) >> 8));
		rd(swt_pkg::ADDR_WAKE_CNT_LO, 8'(m - 1));
		for (int k = 1; k <= 2; k++)
		begin
			go_to(step * m * k - 1);
			chk(16'(interrupt_request_pin_n), 16'h0001);
			go_to(step * m * k);
			chk({interrupt_request_pin_n, xtal_wake_request, pin_out[2]}, {~ie, ie, 1'b1});
			rd(swt_pkg::ADDR_WAKE_CNT_LO, 8'h00);
			rd(7'h03, 8'h00);
			rd(7'h04, 8'h00);
			wake_irq_ack = 1'b1;
			@(negedge ref_clk);
			wake_irq_ack = 1'b0;
			@(negedge ref_clk);
			chk(16'(interrupt_request_pin_n), 16'h0001);
		end
		sleep_mode = 1'b0;
		wake_run_enable = 1'b0;
		lf_run = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(16'(xtal_wake_request), 16'h0000);
	endtask

	task automatic close_out();
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		{rst, por_active, mcu_clk} = 3'h7;
		{lf_rc_osc, lf_xtal_osc, low_freq_crystal_select, wake_run_enable} = 4'h0;
		{wake_irq_enable, wake_irq_ack, sleep_mode, shutdown_mode} = 4'h0;
		{pin_in, seed, bad_count, n_tests, rises, stop_at, ph, lf_run} = '0;
		seed = 32'h4f29;
		foreach (mdl[i])
			mdl[i] = 0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({pin_oe_n, pin_out}, 6'h05);
		{por_active, mcu_clk} = 2'h0;
		repeat (2) @(negedge ref_clk);
		chk({pin_oe_n, pin_out}, 6'h02);
		wr(7'h17, 8'($random(seed)));
		wr(7'h30, 8'($random(seed)));
		foreach (addrs[i])
			rd(addrs[i], 8'(mdl[addrs[i]]));
		// random strength and pull-up; pin 0 driven from the port bits, pin 1 input,
		// pin 2 timer output; no converter input code is chosen in low-power modes
		for (int i = 0; i < 3; i++)
		begin
			d = 8'($random(seed));
			wr(7'h0b + 7'(i), {d[7:5], i == 0 ? 5'h0a : i == 1 ? 5'h03 : 5'h01});
			rd(7'h0b + 7'(i), 8'(mdl[7'h0b + i]));
		end
		chk({pin_drive_strength, pin_pullup_enable}, {mdl[13][7:6], mdl[12][7:6], mdl[11][7:6],
			mdl[13][5], mdl[12][5], mdl[11][5]});
		d = 8'($random(seed));
		pin_in = 3'($random(seed));
		wr(7'h0e, d);
		chk({pin_oe_n, pin_out[0]}, {3'h2, d[0]});
		rd(7'h0e, (8'(mdl[14]) & 8'hfd) | {6'h00, pin_in[1], 1'b0});
		shutdown_mode = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({pin_out, pin_oe_n, pin_pullup_enable}, 16'h0000);
		shutdown_mode = 1'b0;
		// fine divider used where the exponent alone is too coarse, and also where it gives the same step
		wake(4'h0, 2'h0, 16'h0002, 1'b0, 1'b1);
		wake(4'h2, 2'h1, 16'h0002 + 16'($unsigned($random(seed)) % 3), 1'b0, 1'b1);
		wake(4'h1, 2'h2, 16'h0003, 1'b1, 1'b1);
		chk({lf_clk_is_crystal, pin_oe_n[0]}, 2'h3);
		wake(4'h0, 2'h2, 16'h0101, 1'b1, 1'b1);
		wake(4'h3, 2'h3, 16'h0002, 1'b0, 1'b1);
		wake(4'h1, 2'h0, 16'h0002, 1'b0, 1'b0);
		close_out();
	end

	// the full sequence needs some 17000 cycles; allow about three and a half times that
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		close_out();
	end
endmodule // tb_swt_sleep_wake_timer

`default_nettype wire
